// *** verilog/eeprom_spi_pkg.sv ***
package eeprom_spi_pkg;

  // Array geometry
  localparam int unsigned ADDR_W   = 12;
  localparam int unsigned PAGE_W   = 5;

  // Instruction bytes, bit 3 masked off before compare
  localparam logic [7:0] OPC_MASK          = 8'hF7;
  localparam logic [7:0] OPC_SET_LATCH     = 8'h06;
  localparam logic [7:0] OPC_CLEAR_LATCH   = 8'h04;
  localparam logic [7:0] OPC_STATUS_READ   = 8'h05;
  localparam logic [7:0] OPC_STATUS_WRITE  = 8'h01;
  localparam logic [7:0] OPC_ARRAY_READ    = 8'h03;
  localparam logic [7:0] OPC_ARRAY_WRITE   = 8'h02;

  // Status register field positions
  localparam int unsigned ST_BUSY    = 0;
  localparam int unsigned ST_LATCH   = 1;
  localparam int unsigned ST_LVL_LO  = 2;
  localparam int unsigned ST_LVL_HI  = 3;
  localparam int unsigned ST_ARM     = 7;
  localparam logic [7:0]  ST_WRITING = 8'hFF;

  // Reset values of the stored status fields
  localparam logic       LATCH_RESET = 1'b0;
  localparam logic [1:0] LEVEL_RESET = 2'h0;
  localparam logic       ARM_RESET   = 1'b0;

  // Protection levels and lowest protected address of the quarter and half levels
  localparam logic [1:0]        LVL_NONE    = 2'h0;
  localparam logic [1:0]        LVL_QUARTER = 2'h1;
  localparam logic [1:0]        LVL_HALF    = 2'h2;
  localparam logic [ADDR_W-1:0] BASE_QUARTER = 12'hC00;
  localparam logic [ADDR_W-1:0] BASE_HALF    = 12'h800;

  // Self-timed write cycle
  localparam int unsigned CLK_PERIOD_NS = 50;
  localparam int unsigned WRITE_TIME_NS = 5000000;
  localparam int unsigned WRITE_CYCLES  = WRITE_TIME_NS / CLK_PERIOD_NS;

endpackage : eeprom_spi_pkg

// *** verilog/eeprom_spi_slave.sv ***
`timescale 1ns/100ps
module eeprom_spi_slave #(
  parameter int unsigned WRITE_CYCLES = eeprom_spi_pkg::WRITE_CYCLES
) (
  // System clock and reset
  input  wire logic i_clk,
  input  wire logic i_reset,
  // Serial link from the master
  input  wire logic i_sck,
  input  wire logic i_chip_select_n,
  input  wire logic i_si,
  input  wire logic i_write_protect_n,
  // Serial output pin
  output logic      o_so,
  output logic      o_so_oe
);

  localparam int unsigned AW = eeprom_spi_pkg::ADDR_W;
  localparam int unsigned PW = eeprom_spi_pkg::PAGE_W;

  if (WRITE_CYCLES < 1) begin : g_bad_cycles
    $error("WRITE_CYCLES must be at least one");
  end

  typedef enum logic [2:0] {
    PH_OPCODE  = 3'b000,
    PH_ADDR_HI = 3'b001,
    PH_ADDR_LO = 3'b010,
    PH_DATA    = 3'b011,
    PH_IGNORE  = 3'b100
  } phase_e;

  // Lowest-address test for the active protection level
  function automatic logic is_protected(input logic [1:0] lvl, input logic [AW-1:0] a);
    logic hit;
    hit = 1'b1;
    case (lvl)
      eeprom_spi_pkg::LVL_NONE:    hit = 1'b0;
      eeprom_spi_pkg::LVL_QUARTER: hit = (a >= eeprom_spi_pkg::BASE_QUARTER);
      eeprom_spi_pkg::LVL_HALF:    hit = (a >= eeprom_spi_pkg::BASE_HALF);
      default:                     hit = 1'b1;
    endcase
    return hit;
  endfunction : is_protected

  // ---------------- Link domain (serial clock) ----------------
  logic [7:0]    mem [0:(1<<AW)-1];
  phase_e        phase;
  logic [2:0]    bit_idx;
  logic [6:0]    shift_in;
  logic [7:0]    cmd;
  logic [AW-1:0] addr;
  logic [7:0]    tx_byte;
  logic          out_active;
  // Frame results, held after select rises for the system side
  logic          res_set_latch;
  logic          res_clear_latch;
  logic          res_status_write;
  logic [7:0]    res_status_data;
  logic          res_array_write;
  logic          res_array_stored;
  // Status image owned by the system side, frame-static
  logic [7:0]    status_view;

  wire logic          frame_rst  = i_chip_select_n | i_reset;
  wire logic          byte_done  = (bit_idx == 3'h7);
  wire logic [7:0]    byte_val   = {shift_in, i_si};
  wire logic [7:0]    opc        = byte_val & eeprom_spi_pkg::OPC_MASK;
  wire logic          busy_view  = status_view[eeprom_spi_pkg::ST_BUSY];
  wire logic          latch_view = status_view[eeprom_spi_pkg::ST_LATCH];
  wire logic [1:0]    lvl_view   = {status_view[eeprom_spi_pkg::ST_LVL_HI],
                                    status_view[eeprom_spi_pkg::ST_LVL_LO]};
  wire logic          at_opcode  = (phase == PH_OPCODE) && byte_done;
  wire logic          at_data    = (phase == PH_DATA) && byte_done;
  wire logic          frame_first = (phase == PH_OPCODE) && (bit_idx == 3'h0);
  // Busy refuses everything except the status read
  wire logic          opc_allowed = !busy_view ||
                                    (opc == eeprom_spi_pkg::OPC_STATUS_READ);
  wire logic          ev_set     = at_opcode && opc_allowed &&
                                   (opc == eeprom_spi_pkg::OPC_SET_LATCH);
  wire logic          ev_clear   = at_opcode && opc_allowed &&
                                   (opc == eeprom_spi_pkg::OPC_CLEAR_LATCH);
  wire logic          is_rd      = (cmd == eeprom_spi_pkg::OPC_ARRAY_READ);
  wire logic          is_wr      = (cmd == eeprom_spi_pkg::OPC_ARRAY_WRITE);
  wire logic          is_sr      = (cmd == eeprom_spi_pkg::OPC_STATUS_READ);
  wire logic          is_sw      = (cmd == eeprom_spi_pkg::OPC_STATUS_WRITE);
  wire logic [AW-1:0] lo_addr    = {addr[AW-1:8], byte_val};
  // Latch set and level clear of this address, else the byte is dropped
  wire logic          wr_ok      = latch_view &&
                                   !is_protected(lvl_view, addr);
  wire logic          ev_store   = at_data && is_wr && wr_ok;
  wire logic          ev_sw      = at_data && is_sw;
  wire logic [AW-1:0] page_next  = {addr[AW-1:PW], addr[PW-1:0] + 5'h01};

  // Next phase after each completed byte
  phase_e next_phase;
  always_comb begin
    next_phase = phase;
    if (byte_done) begin
      case (phase)
        PH_OPCODE: begin
          if (!opc_allowed) begin
            next_phase = PH_IGNORE;
          end else if (opc == eeprom_spi_pkg::OPC_STATUS_READ ||
                       opc == eeprom_spi_pkg::OPC_STATUS_WRITE) begin
            next_phase = PH_DATA;
          end else if (opc == eeprom_spi_pkg::OPC_ARRAY_READ ||
                       opc == eeprom_spi_pkg::OPC_ARRAY_WRITE) begin
            next_phase = PH_ADDR_HI;
          end else begin
            next_phase = PH_IGNORE;
          end
        end
        PH_ADDR_HI: next_phase = PH_ADDR_LO;
        PH_ADDR_LO: next_phase = PH_DATA;
        PH_DATA:    next_phase = is_sw ? PH_IGNORE : PH_DATA;
        PH_IGNORE:  next_phase = PH_IGNORE;
        default:    next_phase = PH_IGNORE;
      endcase
    end
  end

  // Bit framing; select high clears it at once
  always_ff @(posedge i_sck or posedge frame_rst) begin
    if (frame_rst) begin
      phase    <= PH_OPCODE;
      bit_idx  <= 3'h0;
      shift_in <= 7'h00;
    end else begin
      phase    <= next_phase;
      bit_idx  <= bit_idx + 3'h1;
      shift_in <= byte_val[6:0];
    end
  end

  // Command, address and outgoing byte
  always_ff @(posedge i_sck or posedge frame_rst) begin
    if (frame_rst) begin
      cmd        <= 8'h00;
      addr       <= '0;
      tx_byte    <= 8'h00;
      out_active <= 1'b0;
    end else if (at_opcode) begin
      cmd <= opc;
      if (opc_allowed && opc == eeprom_spi_pkg::OPC_STATUS_READ) begin
        tx_byte    <= status_view;
        out_active <= 1'b1;
      end
    end else if (byte_done && phase == PH_ADDR_HI) begin
      addr <= {byte_val[AW-9:0], addr[7:0]}; // Upper address bits are don't care
    end else if (byte_done && phase == PH_ADDR_LO) begin
      if (is_rd) begin
        tx_byte    <= mem[lo_addr];
        addr       <= lo_addr + 12'h001;
        out_active <= 1'b1;
      end else begin
        addr <= lo_addr;
      end
    end else if (at_data) begin
      if (is_sr) begin
        tx_byte <= status_view;
      end else if (is_rd) begin
        tx_byte <= mem[addr];
        addr    <= addr + 12'h001; // Natural wrap to zero
      end else if (is_wr) begin
        addr <= page_next;
      end
    end
  end

  // Array storage; no reset, contents are nonvolatile
  always_ff @(posedge i_sck) begin
    if (ev_store) begin
      mem[addr] <= byte_val;
    end
  end

  // Frame results survive select rise until next frame starts
  always_ff @(posedge i_sck or posedge i_reset) begin
    if (i_reset) begin
      res_set_latch    <= 1'b0;
      res_clear_latch  <= 1'b0;
      res_status_write <= 1'b0;
      res_status_data  <= 8'h00;
      res_array_write  <= 1'b0;
      res_array_stored <= 1'b0;
    end else begin
      if (frame_first) begin
        res_set_latch    <= 1'b0;
        res_clear_latch  <= 1'b0;
        res_status_write <= 1'b0;
        res_array_write  <= 1'b0;
        res_array_stored <= 1'b0;
      end
      if (ev_set) begin
        res_set_latch <= 1'b1;
      end
      if (ev_clear) begin
        res_clear_latch <= 1'b1;
      end
      if (ev_sw) begin
        res_status_write <= 1'b1;
        res_status_data  <= byte_val;
      end
      if (at_data && is_wr) begin
        res_array_write <= 1'b1;
      end
      if (ev_store) begin
        res_array_stored <= 1'b1;
      end
    end
  end

  // Falling edge drives the pin; select high floats it
  wire logic [2:0] out_idx = 3'h7 - bit_idx;
  always_ff @(negedge i_sck or posedge frame_rst) begin
    if (frame_rst) begin
      o_so    <= 1'b0;
      o_so_oe <= 1'b0;
    end else begin
      o_so    <= out_active & tx_byte[out_idx];
      o_so_oe <= out_active;
    end
  end

  // ---------------- System domain ----------------
  logic [2:0]  cs_sync;
  logic [2:0]  wp_sync;
  logic        cs_high;
  logic        wp_high;
  logic        latch;
  logic [1:0]  level;
  logic        arm;
  logic        busy;
  logic [31:0] busy_cnt;
  logic        pend_valid;
  logic [7:0]  pend_data;

  // Change counts when second and third stages agree
  wire logic cs_agree_hi = cs_sync[1] & cs_sync[2];
  wire logic cs_agree_lo = ~cs_sync[1] & ~cs_sync[2];
  wire logic wp_agree_hi = wp_sync[1] & wp_sync[2];
  wire logic wp_agree_lo = ~wp_sync[1] & ~wp_sync[2];
  wire logic cs_rise     = cs_agree_hi & ~cs_high;
  wire logic hw_prot     = arm & ~wp_high;
  wire logic sw_accept   = res_status_write & latch & ~hw_prot;
  wire logic aw_start    = res_array_write & res_array_stored;
  wire logic cycle_end   = busy && (busy_cnt == WRITE_CYCLES - 1);
  wire logic new_arm     = pend_data[eeprom_spi_pkg::ST_ARM];
  // Arm may drop only while the pin is high
  wire logic arm_next    = (!new_arm && !wp_high) ? arm : new_arm;

  // Pin synchronisers, three stages
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      cs_sync <= 3'h7;
      wp_sync <= 3'h7;
    end else begin
      cs_sync <= {cs_sync[1:0], i_chip_select_n};
      wp_sync <= {wp_sync[1:0], i_write_protect_n};
    end
  end

  // Filtered pin levels
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      cs_high <= 1'b1;
      wp_high <= 1'b1;
    end else begin
      if (cs_agree_hi || cs_agree_lo) begin
        cs_high <= cs_agree_hi;
      end
      if (wp_agree_hi || wp_agree_lo) begin
        wp_high <= wp_agree_hi;
      end
    end
  end

  // Write latch: power-up clear, set and clear from frames
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      latch <= eeprom_spi_pkg::LATCH_RESET;
    end else if (cs_rise && !busy) begin
      if (res_set_latch) begin
        latch <= 1'b1;
      end else if (res_clear_latch || sw_accept || res_array_write) begin
        latch <= 1'b0;
      end
    end
  end

  // Self-timed cycle with pending status held until its end
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      busy       <= 1'b0;
      busy_cnt   <= 32'h0;
      pend_valid <= 1'b0;
      pend_data  <= 8'h00;
    end else if (cs_rise && !busy && (sw_accept || aw_start)) begin
      busy       <= 1'b1;
      busy_cnt   <= 32'h0;
      pend_valid <= sw_accept;
      pend_data  <= res_status_data;
    end else if (cycle_end) begin
      busy       <= 1'b0;
      pend_valid <= 1'b0;
    end else if (busy) begin
      busy_cnt <= busy_cnt + 32'h1;
    end
  end

  // Stored level and arm, updated only at cycle end
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      level <= eeprom_spi_pkg::LEVEL_RESET;
      arm   <= eeprom_spi_pkg::ARM_RESET;
    end else if (cycle_end && pend_valid) begin
      level <= {pend_data[eeprom_spi_pkg::ST_LVL_HI],
                pend_data[eeprom_spi_pkg::ST_LVL_LO]};
      arm   <= arm_next;
    end
  end

  // Status image refreshed only while deselected, so it holds still
  // for the whole of a frame; pollers see busy end on a later frame
  wire logic [7:0] status_now = busy ? eeprom_spi_pkg::ST_WRITING :
                                {arm, 3'h0, level, latch, 1'b0};
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      status_view <= 8'h00;
    end else if (cs_high && !cs_rise) begin
      status_view <= status_now;
    end
  end

endmodule : eeprom_spi_slave

// *** sim/eeprom_spi_slave_properties.sv ***
`timescale 1ns/100ps
// Pin-level watcher of the serial slave
module eeprom_spi_props #(
  parameter int unsigned WRITE_CYCLES = 20
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_reset,
  // Link inputs
  input wire logic i_sck,
  input wire logic i_chip_select_n,
  input wire logic i_si,
  input wire logic i_write_protect_n,
  // Serial output
  input wire logic o_so,
  input wire logic o_so_oe
);
  logic [5:0] cnt;
  logic [7:0] op;
  wire  [7:0] op_m;
  wire        is_quiet;
  wire        frame_off;
  // Link checks sleep in reset and between frames
  assign frame_off = i_reset | i_chip_select_n;
  // Bits seen this frame; select high clears it, so no stale count
  always_ff @(posedge i_sck or posedge i_chip_select_n) begin
    if (i_chip_select_n) begin
      cnt <= 6'h00;
      op  <= 8'h00;
    end else begin
      if (cnt != 6'h3F) cnt <= cnt + 6'h01;
      if (cnt < 6'h08) op <= {op[6:0], i_si};
    end
  end
  // Opcodes that never return data
  assign op_m = op & eeprom_spi_pkg::OPC_MASK;
  assign is_quiet = op_m == eeprom_spi_pkg::OPC_SET_LATCH ||
                    op_m == eeprom_spi_pkg::OPC_CLEAR_LATCH ||
                    op_m == eeprom_spi_pkg::OPC_STATUS_WRITE ||
                    op_m == eeprom_spi_pkg::OPC_ARRAY_WRITE;
  sequence s_status_op;
    cnt >= 6'h08 && op_m == eeprom_spi_pkg::OPC_STATUS_READ;
  endsequence
  sequence s_read_addr;
    cnt >= 6'h08 && cnt < 6'h18 && op_m == eeprom_spi_pkg::OPC_ARRAY_READ;
  endsequence
  off_deselect_a: assert property (@(posedge i_clk) disable iff (i_reset)
    i_chip_select_n && $past(i_chip_select_n) |-> !o_so_oe) else $error("driven while idle");
  quiet_reset_a: assert property (@(posedge i_clk)
    i_reset |-> !o_so_oe && !o_so) else $error("driven in reset");
  quiet_opcode_a: assert property (@(posedge i_sck) disable iff (frame_off)
    cnt < 6'h08 |-> !o_so_oe) else $error("driven during opcode");
  status_drives_a: assert property (@(posedge i_sck) disable iff (frame_off)
    s_status_op |-> o_so_oe) else $error("status read not answered");
  status_repeat_a: assert property (@(posedge i_sck) disable iff (frame_off)
    s_status_op ##0 cnt >= 6'h10 |-> o_so == $past(o_so, 8)) else $error("status not repeated");
  addr_quiet_a: assert property (@(posedge i_sck) disable iff (frame_off)
    s_read_addr |-> !o_so_oe) else $error("driven during address");
  write_quiet_a: assert property (@(posedge i_sck) disable iff (frame_off)
    cnt >= 6'h08 && is_quiet |-> !o_so_oe) else $error("driven on a write opcode");
  oe_holds_a: assert property (@(posedge i_sck) disable iff (frame_off)
    cnt >= 6'h09 && $past(o_so_oe) |-> o_so_oe) else $error("output dropped mid frame");
endmodule : eeprom_spi_props

// *** sim/spi_master_model.sv ***
`timescale 1ns/100ps
// Bus master; its clock only runs inside frames
module spi_master_model (
  // Link toward the device
  output logic      o_sck,
  output logic      o_chip_select_n,
  output logic      o_si,
  // Answer from the device
  input  wire logic i_so,
  input  wire logic i_so_oe
);
  logic mode3;
  initial begin
    mode3           = 1'b0;
    o_sck           = 1'b0;
    o_chip_select_n = 1'b1;
    o_si            = 1'b0;
  end
  // One frame, MSB first, read on rising edge
  task automatic xfer(input logic [39:0] tx, input int n, output logic [39:0] rx);
    rx = '0;
    o_sck = mode3;
    #20 o_chip_select_n = 1'b0;
    #16;
    for (int i = n - 1; i >= 0; i--) begin
      o_sck = 1'b0;
      o_si  = tx[i];
      #16 o_sck = 1'b1;
      rx = {rx[38:0], i_so_oe ? i_so : 1'bz};
      #16;
    end
    if (!mode3) o_sck = 1'b0;
    // Select rises before any further rising edge
    #16 o_chip_select_n = 1'b1;
    o_si = ~o_si; // Released line keeps no stale value
    #400;
  endtask : xfer
endmodule : spi_master_model

// *** sim/tb.sv ***
`timescale 1ns/100ps
module tb;
  logic        i_clk;
  logic        i_reset;
  logic        i_write_protect_n;
  logic        sck;
  logic        cs_n;
  logic        si;
  logic        o_so;
  logic        o_so_oe;
  logic [39:0] rx;
  int          n_errors;
  int          n_checks;
  eeprom_spi_slave #(.WRITE_CYCLES(60)) uut (.i_clk(i_clk), .i_reset(i_reset), .i_sck(sck),
    .i_chip_select_n(cs_n), .i_si(si), .i_write_protect_n(i_write_protect_n),
    .o_so(o_so), .o_so_oe(o_so_oe));
  spi_master_model m (.o_sck(sck), .o_chip_select_n(cs_n), .o_si(si), .i_so(o_so),
    .i_so_oe(o_so_oe));
  initial begin
    i_clk = 1'b0;
    forever #25 i_clk = ~i_clk;
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // Opcodes go out as given; t_latch also sends them with bit 3 set
  task automatic xf(input logic [39:0] tx, input int n);
    m.xfer(tx, n, rx);
  endtask : xf
  task automatic st(input logic [7:0] e);
    xf(40'h050000, 24);
    chk(rx[15:0], {e, e});
  endtask : st
  task automatic ready();
    int k;
    k = 0;
    do begin
      xf(40'h0500, 16);
      k++;
    end while (rx[0] !== 1'b0 && k < 40);
    chk({8'h00, 7'h00, rx[0]}, 16'h0000);
  endtask : ready
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    xf(40'h06, 8);
    xf({8'h00, 8'h02, 4'h0, a, d}, 32);
    ready();
  endtask : wr
  task automatic rd(input logic [11:0] a);
    xf({8'h03, 4'h0, a, 16'h0000}, 40);
  endtask : rd
  task automatic t_latch();
    st(8'h00);
    for (int i = 0; i < 2; i++) begin
      xf({32'h0, 4'h0, i[0], 3'h6}, 8);
      st(8'h02);
      xf({32'h0, 4'h0, i[0], 3'h4}, 8);
      st(8'h00);
    end
    $display("t_latch done");
  endtask : t_latch
  task automatic t_status();
    xf(40'h06, 8);
    xf(40'h01FF, 16);
    st(8'hFF);
    xf(40'h06, 8);
    ready();
    m.mode3 = 1'b1;
    st(8'h8C);
    m.mode3 = 1'b0;
    $display("t_status done");
  endtask : t_status
  task automatic t_protect();
    @(negedge i_clk) i_write_protect_n = 1'b0;
    xf(40'h06, 8);
    xf(40'h0100, 16);
    st(8'h8E);
    @(negedge i_clk) i_write_protect_n = 1'b1;
    xf(40'h0100, 16);
    // Pin drops during the cycle, so the arm must survive its end
    @(negedge i_clk) i_write_protect_n = 1'b0;
    ready();
    st(8'h80);
    @(negedge i_clk) i_write_protect_n = 1'b1;
    xf(40'h06, 8);
    xf(40'h0100, 16);
    ready();
    st(8'h00);
    $display("t_protect done");
  endtask : t_protect
  task automatic t_levels();
    logic [7:0] e7;
    logic [7:0] ec;
    for (int l = 0; l < 4; l++) begin
      xf(40'h06, 8);
      xf({24'h0, 8'h01, 4'h0, l[1:0], 2'h0}, 16);
      ready();
      st({4'h0, l[1:0], 2'h0});
      wr(12'h7FF, 8'h10 + 8'(l));
      wr(12'hC00, 8'h20 + 8'(l));
      if (l < 3) e7 = 8'h10 + 8'(l);
      if (l == 0) ec = 8'h20;
      rd(12'h7FF);
      chk({8'h00, rx[15:8]}, {8'h00, e7});
      rd(12'hC00);
      chk({8'h00, rx[15:8]}, {8'h00, ec});
    end
    $display("t_levels done");
  endtask : t_levels
  task automatic t_wrap();
    xf(40'h06, 8);
    xf(40'h0100, 16);
    ready();
    wr(12'hFFF, 8'hA5);
    wr(12'h000, 8'h3C);
    rd(12'hFFF);
    chk(rx[15:0], 16'hA53C);
    st(8'h00);
    $display("t_wrap done");
  endtask : t_wrap
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : summarize
  // Main sequence; select stays high through reset
  initial begin
    i_reset = 1'b1;
    i_write_protect_n = 1'b1;
    n_errors = 0;
    n_checks = 0;
    repeat (16) @(posedge i_clk);
    @(negedge i_clk) i_reset = 1'b0;
    repeat (4) @(negedge i_clk);
    t_latch();
    t_status();
    t_protect();
    t_levels();
    t_wrap();
    summarize();
  end
  // Watchdog, over ten times the expected run
  initial begin
    #2000000;
    n_errors++;
    summarize();
  end
endmodule : tb
bind eeprom_spi_slave eeprom_spi_props #(.WRITE_CYCLES(WRITE_CYCLES)) chk_i (.i_clk(i_clk),
  .i_reset(i_reset), .i_sck(i_sck), .i_chip_select_n(i_chip_select_n), .i_si(i_si),
  .i_write_protect_n(i_write_protect_n), .o_so(o_so), .o_so_oe(o_so_oe));
